/* File: fpt_pkg.sv */
// Constants and types for the front panel test mode sequencer.
// Assumes a 125 MHz system clock and debounced, synchronous buttons.
package fpt_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ = 125;                  // System clock rate
	localparam int ENTRY_WINDOW_MS = 3000;         // Power-up entry window
	localparam int TICK_MS = 1;                    // Millisecond tick period
	localparam int TICK_CYCLES = CLK_MHZ * 1000 * TICK_MS; // Cycles per tick
	localparam int LED_STEP_MS = 250;              // LED walk step time
	localparam int ENTRY_PRESSES = 3;              // Presses for entry or exit
	// ****************************************
	// Button indices and codes
	// ****************************************
	localparam int BTN_W = 6;                      // Number of front buttons
	localparam int BTN_LEFT = 0;                   // Previous item key
	localparam int BTN_RIGHT = 1;                  // Next item key
	localparam int BTN_DOWN = 2;                   // Down arrow
	localparam int BTN_UP = 3;                     // Up arrow
	localparam int BTN_ESC = 4;                    // Exit key, also trim point step and relay 0
	localparam int BTN_ENTER = 5;                  // Enter key
	localparam logic [3:0] CODE_NONE = 4'h0;       // Shown when nothing pressed
	localparam logic [3:0] CODE_BASE = 4'h6;       // Code of button index 0
	localparam int DIGITS = 5;                     // Display digits
	localparam int STATUS_W = 8;                   // Status LEDs, upper half then lower
	localparam int TRIM_W = 8;                     // Signed trim width
	// Analog option
	typedef enum logic [1:0] {OPT_CURRENT, OPT_UNIPOLAR_V, OPT_BIPOLAR_V} fpt_opt_e;
	// Test items in visiting order
	typedef enum logic [2:0] {
		ITEM_MODEL, ITEM_VERSION, ITEM_LED, ITEM_BUTTON, ITEM_OUTPUT, ITEM_INPUT, ITEM_ANALOG
	} fpt_item_e;
	// Top mode
	typedef enum logic [1:0] {MODE_MEASURE, MODE_ARMED, MODE_TEST} fpt_mode_e;
endpackage

/* File: fpt_trim_mem.sv */
`timescale 1ns/1ps
// Three-word trim store standing in for retained memory.
// Assumes one write port and a registered read.
module fpt_trim_mem #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Write port
	input wire logic wrEn,
	input wire logic [1:0] wrAddr,
	input wire logic [W-1:0] wrData,
	// Read port
	input wire logic [1:0] rdAddr,
	output logic [W-1:0] rdData
);
	logic [W-1:0] mem [0:2]; // Storage, no reset like real retained cells
	// ****************************************
	// Write and registered read
	// ****************************************
	always_ff @(posedge clock) begin
		if (wrEn && wrAddr != 2'h3) begin
			mem[wrAddr] <= wrData;
		end
	end
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdData <= '0;
		end else begin
			rdData <= (rdAddr == 2'h3) ? '0 : mem[rdAddr];
		end
	end
endmodule

/* File: fpt_sequencer.sv */
`timescale 1ns/1ps
// Front panel test mode sequencer: entry, exit, item stepping and items.
// Assumes buttons are debounced, active high and synchronous to clock.
// How it works
// - Function menu: arm, then three presses enter
// - Button held at power-up enters test
// - Three presses within three seconds enter
// - Three exit presses on first items leave
// - Next key advances, previous key goes back
// - LED item walks seven phases repeatedly
// - Button item shows pressed code, zero idle
// - Button item needs double presses to move
// - Four relays toggle, number shown per digit
// - Three external inputs shown one per digit
// - Analog first point lower end trimmed
// - Further press selects upper end point
// - Bipolar adds minus five; enter stores trims
// - Test mode drives outputs from manual actions
module fpt_sequencer
	import fpt_pkg::*;
#(
	parameter int WINDOW_TICKS = fpt_pkg::ENTRY_WINDOW_MS, // Shorten for simulation
	parameter int TICK_LEN = fpt_pkg::TICK_CYCLES          // Shorten for simulation
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Operator inputs
	input wire logic [fpt_pkg::BTN_W-1:0] buttons,
	input wire logic testSelected,
	input wire fpt_pkg::fpt_opt_e outOption,
	// External inputs
	input wire logic autoZeroInput,
	input wire logic autoZeroReleaseInput,
	input wire logic commandInput,
	// Measurement path
	input wire logic [3:0] measDigits [fpt_pkg::DIGITS],
	input wire logic [3:0] measRelays,
	// Display and outputs
	output logic testActive,
	output logic blink,
	output logic [6:0] segments [fpt_pkg::DIGITS],
	output logic [fpt_pkg::STATUS_W-1:0] statusLeds,
	output logic [3:0] relays,
	output logic signed [fpt_pkg::TRIM_W-1:0] trimValue,
	output logic [1:0] trimPoint,
	output logic trimStore
);
	import fpt_pkg::*;
	localparam int LED_TICKS = LED_STEP_MS / TICK_MS; // Ticks per walk step

	// Seven-segment pattern for a decimal digit, E above nine
	function automatic logic [6:0] seg7(input logic [3:0] d);
		case (d)
			4'h0: seg7 = 7'h3f;
			4'h1: seg7 = 7'h06;
			4'h2: seg7 = 7'h5b;
			4'h3: seg7 = 7'h4f;
			4'h4: seg7 = 7'h66;
			4'h5: seg7 = 7'h6d;
			4'h6: seg7 = 7'h7d;
			4'h7: seg7 = 7'h07;
			4'h8: seg7 = 7'h7f;
			4'h9: seg7 = 7'h6f;
			default: seg7 = 7'h79;
		endcase
	endfunction

	// Index of the last trim point for the fitted option
	function automatic logic [1:0] lastPoint(input fpt_opt_e o);
		lastPoint = (o == OPT_BIPOLAR_V) ? 2'h2 : 2'h1;
	endfunction

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		fpt_mode_e mode;          // Measuring, armed or test
		fpt_item_e item;          // Current test item
		logic [BTN_W-1:0] btnPrev; // Last cycle buttons, edge detect
		logic started;            // Power-up strap sampled
		logic [1:0] pressCnt;     // Entry or exit press count
		logic [1:0] navCnt;       // Double press count, button item
		logic navDir;             // Direction of pending double press
		logic [31:0] tickCnt;     // Divider to millisecond tick
		logic [15:0] winCnt;      // Power-up window in ticks
		logic [15:0] ledCnt;      // LED step timer in ticks
		logic [5:0] ledStep;      // LED walk position
		logic [3:0] relayState;   // Manual relay states
		logic [1:0] point;        // Analog trim point
		logic [3*TRIM_W-1:0] trims; // Working trim offsets
		logic store;              // Store pulse
		logic [1:0] storeIdx;     // Word being stored
	} fpt_state_s;
	fpt_state_s st_reg, st_next;

	logic [BTN_W-1:0] press; // One-cycle press edges
	logic tick;              // Millisecond enable
	logic inWindow;          // Within power-up entry window
	assign press = buttons & ~st_reg.btnPrev;
	assign tick = (st_reg.tickCnt == 32'(TICK_LEN - 1));
	assign inWindow = (st_reg.winCnt < 16'(WINDOW_TICKS));

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic signed [TRIM_W-1:0] t;
		t = '0;
		st_next = st_reg;
		st_next.btnPrev = buttons;
		st_next.store = 1'b0;
		st_next.tickCnt = tick ? '0 : st_reg.tickCnt + 32'h1;
		if (tick && inWindow) begin
			st_next.winCnt = st_reg.winCnt + 16'h1;
		end
		// Strap caught one clock after reset release
		if (!st_reg.started) begin
			st_next.started = 1'b1;
			st_next.btnPrev = buttons;
			if (buttons[BTN_RIGHT]) begin
				st_next.mode = MODE_TEST;
			end
		end else begin
			case (st_reg.mode)
				MODE_MEASURE: begin
					// Window entry counts presses only inside three seconds
					if (press[BTN_RIGHT] && inWindow) begin
						st_next.pressCnt = st_reg.pressCnt + 2'h1;
						if (st_reg.pressCnt == 2'(ENTRY_PRESSES - 1)) begin
							st_next.mode = MODE_TEST;
							st_next.pressCnt = '0;
						end
					end else if (press[BTN_RIGHT] && testSelected) begin
						st_next.mode = MODE_ARMED;
						st_next.pressCnt = '0;
					end
				end
				MODE_ARMED: begin
					// Indication blinks until three more presses of the arming key
					if (press[BTN_RIGHT]) begin
						st_next.pressCnt = st_reg.pressCnt + 2'h1;
						if (st_reg.pressCnt == 2'(ENTRY_PRESSES - 1)) begin
							st_next.mode = MODE_TEST;
							st_next.pressCnt = '0;
						end
					end else if (!testSelected) begin
						st_next.mode = MODE_MEASURE;
						st_next.pressCnt = '0;
					end
				end
				MODE_TEST: begin
					// Exit counting only on the two identity items
					if (st_reg.item == ITEM_MODEL || st_reg.item == ITEM_VERSION) begin
						if (press[BTN_ESC]) begin
							st_next.pressCnt = st_reg.pressCnt + 2'h1;
							if (st_reg.pressCnt == 2'(ENTRY_PRESSES - 1)) begin
								st_next.mode = MODE_MEASURE;
								st_next.item = ITEM_MODEL;
								st_next.pressCnt = '0;
							end
						end
					end else begin
						st_next.pressCnt = '0;
					end
					// Navigation; button item needs two presses either way
					if (press[BTN_RIGHT] || press[BTN_LEFT]) begin
						if (st_reg.item == ITEM_BUTTON) begin
							if (st_reg.navCnt == 2'h1 && st_reg.navDir == press[BTN_RIGHT]) begin
								st_next.navCnt = '0;
								st_next.item = press[BTN_RIGHT] ? ITEM_OUTPUT : ITEM_VERSION;
							end else begin
								st_next.navCnt = 2'h1;
								st_next.navDir = press[BTN_RIGHT];
							end
						end else if (press[BTN_RIGHT] && st_reg.item != ITEM_ANALOG) begin
							st_next.item = fpt_item_e'(st_reg.item + 3'h1);
						end else if (press[BTN_LEFT] && st_reg.item != ITEM_MODEL) begin
							st_next.item = fpt_item_e'(st_reg.item - 3'h1);
						end
					end
					if (st_next.item != st_reg.item) begin
						st_next.ledStep = '0;
						st_next.ledCnt = '0;
						st_next.point = '0;
						st_next.navCnt = '0;
					end
					case (st_reg.item)
						ITEM_LED: begin
							// Step timer paces the walk; wraps to all off
							if (tick) begin
								st_next.ledCnt = st_reg.ledCnt + 16'h1;
								if (st_reg.ledCnt == 16'(LED_TICKS - 1)) begin
									st_next.ledCnt = '0;
									st_next.ledStep = (st_reg.ledStep == 6'(7 * 5 + STATUS_W + DIGITS + 3))
										? '0 : st_reg.ledStep + 6'h1;
								end
							end
						end
						ITEM_OUTPUT: begin
							// Each arrow, enter and escape toggles its own relay
							if (press[BTN_UP]) st_next.relayState[3] = ~st_reg.relayState[3];
							if (press[BTN_DOWN]) st_next.relayState[2] = ~st_reg.relayState[2];
							if (press[BTN_ENTER]) st_next.relayState[1] = ~st_reg.relayState[1];
							if (press[BTN_ESC]) st_next.relayState[0] = ~st_reg.relayState[0];
						end
						ITEM_ANALOG: begin
							t = st_reg.trims[st_reg.point*TRIM_W +: TRIM_W];
							if (press[BTN_UP]) t = t + 8'sh1;
							if (press[BTN_DOWN]) t = t - 8'sh1;
							st_next.trims[st_reg.point*TRIM_W +: TRIM_W] = t;
							// Escape walks the end points, wrapping to the lower end
							if (press[BTN_ESC]) begin
								st_next.point = (st_reg.point == lastPoint(outOption))
									? 2'h0 : st_reg.point + 2'h1;
							end
							if (press[BTN_ENTER]) begin
								st_next.store = 1'b1;
								st_next.storeIdx = '0;
							end
						end
						default: begin
						end
					endcase
				end
				default: st_next.mode = MODE_MEASURE;
			endcase
		end
		// Store sequence writes all three words one per cycle
		if (st_reg.store && st_reg.storeIdx != 2'h2) begin
			st_next.store = 1'b1;
			st_next.storeIdx = st_reg.storeIdx + 2'h1;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************
	// Retained trim store
	// ****************************************
	logic [TRIM_W-1:0] storedTrim; // Read back of stored point, shown in the analog item
	fpt_trim_mem #(.W(TRIM_W)) fpt_trim_mem_i (
		.clock(clock),
		.resetn(resetn),
		.wrEn(st_reg.store),
		.wrAddr(st_reg.storeIdx),
		.wrData(st_reg.trims[st_reg.storeIdx*TRIM_W +: TRIM_W]),
		.rdAddr(st_reg.point),
		.rdData(storedTrim)
	);

	// ****************************************
	// Display and output drive
	// ****************************************
	logic [6:0] segN [DIGITS]; // Next segment image
	logic [STATUS_W-1:0] statN; // Next status image
	logic [3:0] code;           // Pressed button code
	int s;                      // LED walk index
	always_comb begin
		code = CODE_NONE;
		for (int b = BTN_W - 1; b >= 0; b--) begin
			if (buttons[b]) code = 4'(CODE_BASE + b);
		end
		s = int'(st_reg.ledStep);
		statN = '0;
		for (int d = 0; d < DIGITS; d++) segN[d] = seg7(measDigits[d]);
		if (st_reg.mode == MODE_TEST) begin
			for (int d = 0; d < DIGITS; d++) segN[d] = 7'h00;
			case (st_reg.item)
				ITEM_MODEL: segN[0] = seg7(4'h5);
				ITEM_VERSION: segN[0] = seg7(4'h1);
				ITEM_LED: begin
					// Phases: off, each segment, each status LED, each digit, upper, lower, all
					if (s >= 1 && s <= 35) segN[(s - 1) / 7][(s - 1) % 7] = 1'b1;
					else if (s >= 36 && s <= 43) statN[s - 36] = 1'b1;
					else if (s >= 44 && s <= 48) segN[s - 44] = 7'h7f;
					else if (s == 49) statN[STATUS_W-1:STATUS_W/2] = '1;
					else if (s == 50) statN[STATUS_W/2-1:0] = '1;
					else if (s == 51) begin
						for (int d = 0; d < DIGITS; d++) segN[d] = 7'h7f;
						statN = '1;
					end
				end
				ITEM_BUTTON: segN[DIGITS-1] = seg7(code);
				ITEM_OUTPUT: begin
					for (int r = 0; r < 4; r++) begin
						segN[DIGITS-1-r] = st_reg.relayState[r] ? seg7(4'(r + 1)) : seg7(4'h0);
					end
				end
				ITEM_INPUT: begin
					segN[DIGITS-1] = seg7({3'h0, autoZeroInput});
					segN[DIGITS-2] = seg7({3'h0, autoZeroReleaseInput});
					segN[DIGITS-3] = seg7({3'h0, commandInput});
				end
				ITEM_ANALOG: begin
					segN[0] = seg7({2'h0, st_reg.point});
					// Low nibble of the retained word, so a store can be seen
					segN[DIGITS-1] = seg7(storedTrim[3:0]);
				end
				default: segN[0] = 7'h00;
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			testActive <= 1'b0;
			blink <= 1'b0;
			statusLeds <= '0;
			relays <= '0;
			trimValue <= '0;
			trimPoint <= '0;
			trimStore <= 1'b0;
			for (int d = 0; d < DIGITS; d++) segments[d] <= '0;
		end else begin
			testActive <= (st_reg.mode == MODE_TEST);
			blink <= (st_reg.mode == MODE_ARMED);
			statusLeds <= statN;
			relays <= (st_reg.mode == MODE_TEST) ? st_reg.relayState : measRelays;
			trimValue <= st_reg.trims[st_reg.point*TRIM_W +: TRIM_W];
			trimPoint <= st_reg.point;
			trimStore <= st_reg.store;
			for (int d = 0; d < DIGITS; d++) segments[d] <= segN[d];
		end
	end
endmodule

/* File: fpt_seq_properties.sv */
// Concurrent checks on the ports of the front panel test mode sequencer.
// Assumes it is bound onto fpt_sequencer, with one clock and an async low reset.
`timescale 1ns/1ps
module fpt_seq_properties
	import fpt_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Operator and measuring side
	input wire logic [fpt_pkg::BTN_W-1:0] buttons,
	input wire logic testSelected,
	input wire fpt_pkg::fpt_opt_e outOption,
	input wire logic [3:0] measRelays,
	// Observed outputs
	input wire logic testActive,
	input wire logic blink,
	input wire logic [3:0] relays,
	input wire logic [1:0] trimPoint,
	input wire logic trimStore
);
	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	// Store pulse is a fixed burst, never a stuck level
	AST_STORE_BURST: assert property ($rose(trimStore) |-> trimStore[*3] ##1 !trimStore)
		else $error("store burst is not three cycles long");
	AST_STORE_IN_TEST: assert property (trimStore |-> testActive)
		else $error("store burst outside test mode");
	AST_POINT_RANGE: assert property (trimPoint != 2'h3)
		else $error("trim point out of range");
	AST_MINUS_POINT: assert property (trimPoint == 2'h2 |-> outOption == OPT_BIPOLAR_V)
		else $error("third trim point without bipolar option");
	AST_ARMED_EXCL: assert property (!(blink && testActive))
		else $error("blink and test mode at once");
	// Measuring relays pass through once the mode has settled out of test
	AST_MEAS_RELAYS: assert property ($past(resetn, 2) && !testActive && !$past(testActive)
		&& !$past(testActive, 2) |-> relays == $past(measRelays))
		else $error("relays do not follow measurement outside test");
	AST_RELAY_CAUSE: assert property (testActive && $past(testActive, 3) && $changed(relays)
		|-> $past(|buttons[5:2], 2) || $past(|buttons[5:2], 3))
		else $error("relay changed in test without a key press");
	AST_ARM_CAUSE: assert property ($rose(blink) |-> $past(testSelected) || $past(testSelected, 2))
		else $error("blink started without test entry selected");
	// Main scenarios reached
	cover property ($rose(testActive));
	cover property ($fell(testActive));
	cover property ($rose(trimStore));
	cover property ($rose(blink));
endmodule

/* File: fpt_panel_model.sv */
// Far side model: operator keys, field inputs and the measuring path.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module fpt_panel_model
	import fpt_pkg::*;
(
	// Clock
	input wire logic clock,
	// Keys toward the sequencer
	output logic [fpt_pkg::BTN_W-1:0] buttons,
	// Field inputs
	output logic autoZeroInput,
	output logic autoZeroReleaseInput,
	output logic commandInput,
	// Measuring path
	output logic [3:0] measDigits [fpt_pkg::DIGITS],
	output logic [3:0] measRelays
);
	// Released keys rest at the pulled-down idle level
	initial begin
		buttons = '0;
		autoZeroInput = 1'b1;
		autoZeroReleaseInput = 1'b0;
		commandInput = 1'b1;
		measRelays = 4'h5;
		foreach (measDigits[i]) begin
			measDigits[i] = 4'(i);
		end
	end
	// Hold or drop one key just after an edge
	task automatic setKey(input int idx, input logic level);
		@(posedge clock);
		buttons[idx] <= level;
	endtask
	// One press; a long hold models a slow operator, the gap keeps presses distinct
	task automatic press(input int idx, input int holdCycles);
		setKey(idx, 1'b1);
		repeat (holdCycles) @(posedge clock);
		buttons[idx] <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
endmodule

/* File: test_front_panel_test_mode_sequencer.sv */
// Self-checking bench for the front panel test mode sequencer.
// Assumes the package, design, panel model and checker are compiled first.
`timescale 1ns/1ps
module test_front_panel_test_mode_sequencer;
	import fpt_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic testSelected = 1'b0;
	fpt_opt_e outOption = OPT_BIPOLAR_V;
	logic [BTN_W-1:0] buttons;
	logic autoZeroInput;
	logic autoZeroReleaseInput;
	logic commandInput;
	logic [3:0] measDigits [DIGITS];
	logic [3:0] measRelays;
	logic testActive;
	logic blink;
	logic [3:0] relays;
	logic [6:0] segments [DIGITS];
	logic [STATUS_W-1:0] statusLeds;
	logic signed [TRIM_W-1:0] trimValue;
	logic [1:0] trimPoint;
	logic trimStore;
	int numErrors = 0;
	int comparisons = 0;
	// Short window of 20 ticks of 4 cycles keeps entry tests brief
	fpt_sequencer #(.WINDOW_TICKS(20), .TICK_LEN(4)) fpt_sequencer_i (.clock(clock),
		.resetn(resetn), .buttons(buttons), .testSelected(testSelected), .outOption(outOption),
		.autoZeroInput(autoZeroInput), .autoZeroReleaseInput(autoZeroReleaseInput),
		.commandInput(commandInput), .measDigits(measDigits), .measRelays(measRelays),
		.testActive(testActive), .blink(blink), .segments(segments), .statusLeds(statusLeds),
		.relays(relays),
		.trimValue(trimValue), .trimPoint(trimPoint), .trimStore(trimStore));
	fpt_panel_model fpt_panel_model_i (.clock(clock), .buttons(buttons),
		.autoZeroInput(autoZeroInput), .autoZeroReleaseInput(autoZeroReleaseInput),
		.commandInput(commandInput), .measDigits(measDigits), .measRelays(measRelays));
	// 125 MHz clock
	always #4 clock = ~clock;
	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] expected);
		comparisons++;
		if (got !== expected) begin
			numErrors++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, expected);
		end
	endtask
	task automatic keys(input int idx, input int count, input int holdCycles);
		repeat (count) fpt_panel_model_i.press(idx, holdCycles);
	endtask
	// Twelve cycles of reset, optionally with the entry key held through it
	task automatic doReset(input logic holdEntry);
		@(posedge clock);
		resetn <= 1'b0;
		if (holdEntry) fpt_panel_model_i.setKey(BTN_RIGHT, 1'b1);
		repeat (12) @(posedge clock);
		resetn <= 1'b1;
		repeat (4) @(posedge clock);
		if (holdEntry) fpt_panel_model_i.setKey(BTN_RIGHT, 1'b0);
		repeat (2) @(posedge clock);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_window_entry;
		int k[5] = '{BTN_UP, BTN_DOWN, BTN_ENTER, BTN_ESC, BTN_UP};
		logic [7:0] e[5] = '{8'h08, 8'h0c, 8'h0e, 8'h0f, 8'h07};
		int hits = 0;
		doReset(1'b0);
		keys(BTN_RIGHT, 3, 1);
		chk(8'(testActive), 8'h01);
		// Single presses to the LED item; walk starts all off, then first segment
		keys(BTN_RIGHT, 2, 1);
		chk(8'(segments[0]), 8'h00);
		repeat (1100) @(posedge clock);
		chk(8'(segments[0]), 8'h01);
		chk(8'(statusLeds), 8'h00);
		// Key item: idle code, held down arrow code, then a slow double press out
		fpt_panel_model_i.press(BTN_RIGHT, 1);
		chk(8'(segments[DIGITS-1]), 8'h3f);
		fpt_panel_model_i.setKey(BTN_DOWN, 1'b1);
		repeat (3) @(posedge clock);
		chk(8'(segments[DIGITS-1]), 8'h7f);
		fpt_panel_model_i.setKey(BTN_DOWN, 1'b0);
		keys(BTN_RIGHT, 2, 6);
		for (int i = 0; i < 5; i++) begin
			fpt_panel_model_i.press(k[i], 1);
			chk(8'(relays), e[i]);
		end
		// Input item: auto zero and command on, release input off
		fpt_panel_model_i.press(BTN_RIGHT, 1);
		chk(8'(segments[DIGITS-1]), 8'h06);
		chk(8'(segments[DIGITS-2]), 8'h3f);
		chk(8'(segments[DIGITS-3]), 8'h06);
		fpt_panel_model_i.press(BTN_RIGHT, 1);
		chk(8'(trimPoint), 8'h00);
		fpt_panel_model_i.press(BTN_UP, 1);
		chk(8'(trimValue), 8'h01);
		keys(BTN_DOWN, 2, 1);
		chk(8'(trimValue), 8'hff);
		fpt_panel_model_i.press(BTN_ESC, 1);
		chk(8'(trimPoint), 8'h01);
		fpt_panel_model_i.press(BTN_ESC, 1);
		chk(8'(trimPoint), 8'h02);
		fpt_panel_model_i.press(BTN_ESC, 1);
		chk(8'(trimPoint), 8'h00);
		chk(8'(trimValue), 8'hff);
		// Current option has two points only, so escape wraps from the upper end
		outOption <= OPT_CURRENT;
		fpt_panel_model_i.press(BTN_ESC, 1);
		chk(8'(trimPoint), 8'h01);
		fpt_panel_model_i.press(BTN_ESC, 1);
		chk(8'(trimPoint), 8'h00);
		outOption <= OPT_BIPOLAR_V;
		// Count the store burst while enter is held
		fpt_panel_model_i.setKey(BTN_ENTER, 1'b1);
		repeat (12) begin
			@(posedge clock);
			#1;
			if (trimStore === 1'b1) hits++;
		end
		fpt_panel_model_i.setKey(BTN_ENTER, 1'b0);
		chk(8'(hits), 8'h03);
		// Back to the key item, double press out, then past the first item
		keys(BTN_LEFT, 3, 1);
		keys(BTN_LEFT, 2, 1);
		keys(BTN_LEFT, 3, 1);
		keys(BTN_ESC, 3, 1);
		chk(8'(testActive), 8'h00);
		chk(8'(relays), 8'h05);
		$display("test window_entry done");
	endtask
	task automatic t_late;
		doReset(1'b0);
		repeat (100) @(posedge clock);
		keys(BTN_RIGHT, 3, 1);
		chk(8'(testActive), 8'h00);
		chk(8'(segments[1]), 8'h06);
		$display("test late done");
	endtask
	task automatic t_menu;
		@(posedge clock);
		testSelected <= 1'b1;
		fpt_panel_model_i.press(BTN_RIGHT, 6);
		chk(8'(blink), 8'h01);
		keys(BTN_RIGHT, 2, 1);
		chk(8'(testActive), 8'h00);
		fpt_panel_model_i.press(BTN_RIGHT, 1);
		chk(8'(testActive), 8'h01);
		chk(8'(blink), 8'h00);
		@(posedge clock);
		testSelected <= 1'b0;
		keys(BTN_ESC, 3, 1);
		chk(8'(testActive), 8'h00);
		$display("test menu done");
	endtask
	task automatic t_held;
		doReset(1'b1);
		chk(8'(testActive), 8'h01);
		$display("test held done");
	endtask
	// ****************************************
	// Run control
	// ****************************************
	task automatic closeOut;
		$display("comparisons %0d mismatches %0d", comparisons, numErrors);
		if (numErrors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		t_window_entry();
		t_late();
		t_menu();
		t_held();
		closeOut();
	end
	// Tests need about 1600 cycles; this margin only catches a hang
	initial begin
		repeat (20000) @(posedge clock);
		numErrors++;
		closeOut();
	end
endmodule
bind fpt_sequencer fpt_seq_properties fpt_seq_properties_i (.clock(clock), .resetn(resetn),
	.buttons(buttons), .testSelected(testSelected), .outOption(outOption),
	.measRelays(measRelays), .testActive(testActive), .blink(blink), .relays(relays),
	.trimPoint(trimPoint), .trimStore(trimStore));
